/* File: ruc_loader.sv */
// Remote update configuration loader: sequencer, watchdog, AHB-Lite registers
//
// Behaviour
// - Remote power-up loads page zero first
// - Watchdog expiry recorded, factory image reloaded
// - Watchdog off while factory image active
// - Load error recorded, factory image reloaded
// - Good application load enters user mode
// - User I/O tri-stated until configured
// - After load: clear, enable I/O, run
// - Reconfiguration pin forces reload, then user
// - Chain enable out drives next device
// - PLL settings reshift while device runs
// - Only the byte-wide parallel scheme supported
// - Byte-wide parallel path, 40 MHz
// - Page selects seven applications plus factory
// - Local mode loads application directly
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module ruc_loader #(
    parameter int PLL_WIDTH = 24
) (
    input  wire logic        hclk,            // Clock, 40 MHz
    input  wire logic        hresetn,         // Async reset, active low
    input  wire logic        hsel,            // AHB slave select
    input  wire logic [31:0] haddr,           // AHB address
    input  wire logic [1:0]  htrans,          // AHB transfer type
    input  wire logic        hwrite,          // AHB write
    input  wire logic [2:0]  hsize,           // AHB size
    input  wire logic [31:0] hwdata,          // AHB write data
    input  wire logic        hready,          // AHB ready in
    output logic      [31:0] hrdata,          // AHB read data
    output logic             hreadyout,       // AHB ready out
    output logic             hresp,           // AHB response, always OKAY
    input  wire logic        reconfig_n,      // Reconfiguration pin, low forces reload
    input  wire logic        chain_enable_in, // Chain enable from previous device
    output logic             chain_enable_out,// Chain enable to next device
    output logic      [2:0]  page_sel,        // Page address to config source
    output logic             load_req,        // Level: load in progress
    input  wire logic        cfg_valid,       // Config byte valid
    input  wire logic [7:0]  cfg_data,        // Config byte
    input  wire logic        cfg_done,        // Pulse: image loaded OK
    input  wire logic        cfg_error,       // Pulse: load failed
    output logic             cfg_byte_strobe, // Byte accepted strobe
    output logic      [7:0]  cfg_byte,        // Captured config byte
    output logic             user_io_oe_n,    // Low enables user I/O
    output logic             user_reset,      // Clears user registers
    output logic             user_mode,       // Device in user mode
    output logic             pll_sclk,        // PLL chain strobe
    output logic             pll_sdata,       // PLL chain data
    output logic             pll_update       // Pulse: apply PLL settings
);
    localparam logic [15:0] INIT_CNT = 16'(ruc_pkg::INIT_CYCLES);

    typedef struct packed
    {
        ruc_pkg::ruc_state_e state;
        ruc_pkg::ruc_cause_e cause;
        logic [2:0]          page;
        logic [2:0]          next_page;
        logic                wd_en;
        logic                local_mode;
        logic [31:0]         wd_load;
        logic [31:0]         wd_cnt;
        logic [15:0]         init_cnt;
        logic [PLL_WIDTH-1:0] pll_word;
        logic                pll_start;
        logic                sw_recfg;
        logic                dp_valid;
        logic                dp_write;
        logic [7:0]          dp_addr;
        logic [31:0]         rdata;
        logic                byte_stb;
        logic [7:0]          byte_q;
        logic                reset_pin_seen;
    } ruc_state_s;

    ruc_state_s st;
    ruc_state_s next_st;
    logic       pll_busy;
    logic       factory_active;
    logic [31:0] status_word;

    // ------------------------------------------------------------
    // Derived views
    // ------------------------------------------------------------
    assign factory_active = (st.page == ruc_pkg::FACTORY_PAGE);
    always_comb
    begin
        status_word = '0;
        status_word[ruc_pkg::STAT_CAUSE_LSB +: 2] = st.cause;
        status_word[ruc_pkg::STAT_PAGE_LSB +: 3]  = st.page;
        status_word[ruc_pkg::STAT_STATE_LSB +: 3] = st.state;
        status_word[ruc_pkg::STAT_USER_BIT]       = (st.state == ruc_pkg::RUC_ST_USER);
        status_word[ruc_pkg::STAT_FACT_BIT]       = factory_active;
    end

    // ------------------------------------------------------------
    // Sequencer, watchdog and register file
    // ------------------------------------------------------------
    always_comb
    begin
        next_st           = st;
        next_st.pll_start = 1'b0;
        next_st.byte_stb  = 1'b0;
        next_st.sw_recfg  = 1'b0;

        // AHB address phase capture; every transfer answers with no wait
        next_st.dp_valid = hsel && hready && htrans[1];
        next_st.dp_write = hwrite;
        next_st.dp_addr  = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            case (haddr[7:0])
                ruc_pkg::ADDR_CTRL:     next_st.rdata = {26'h0, st.local_mode, st.wd_en, 1'b0, st.next_page};
                ruc_pkg::ADDR_STATUS:   next_st.rdata = status_word;
                ruc_pkg::ADDR_WD_LOAD:  next_st.rdata = st.wd_load;
                ruc_pkg::ADDR_WD_KICK:  next_st.rdata = st.wd_cnt;
                ruc_pkg::ADDR_PLL_CTRL: next_st.rdata = 32'(st.pll_word);
                ruc_pkg::ADDR_PLL_STAT: next_st.rdata = {31'h0, pll_busy};
                default:                next_st.rdata = 32'h0000_0000;
            endcase
        end

        // Data phase write effects
        if (st.dp_valid && st.dp_write)
        begin
            case (st.dp_addr)
                ruc_pkg::ADDR_CTRL:
                begin
                    // Application pages 1..7; factory page 0 is also accepted, but the command never launches it
                    next_st.next_page  = hwdata[ruc_pkg::CTRL_PAGE_LSB +: 3];
                    next_st.wd_en      = hwdata[ruc_pkg::CTRL_WD_EN_BIT];
                    next_st.local_mode = hwdata[ruc_pkg::CTRL_LOCAL_BIT];
                end
                ruc_pkg::ADDR_WD_LOAD: next_st.wd_load = hwdata;
                ruc_pkg::ADDR_WD_KICK: next_st.wd_cnt  = st.wd_load;
                ruc_pkg::ADDR_PLL_CTRL:
                begin
                    next_st.pll_word  = hwdata[PLL_WIDTH-1:0];
                    next_st.pll_start = !pll_busy;
                end
                ruc_pkg::ADDR_CMD: next_st.sw_recfg = hwdata[ruc_pkg::CMD_RECFG_BIT];
                default: ;
            endcase
        end

        // Byte-wide configuration data path, one byte per clock
        if (st.state == ruc_pkg::RUC_ST_LOAD && cfg_valid)
        begin
            next_st.byte_stb = 1'b1;
            next_st.byte_q   = cfg_data;
        end

        case (st.state)
            ruc_pkg::RUC_ST_POWER:
            begin
                // Local mode jumps straight to the application page
                next_st.page  = st.local_mode ? st.next_page : ruc_pkg::FACTORY_PAGE;
                next_st.state = ruc_pkg::RUC_ST_WAIT_CHAIN;
            end
            ruc_pkg::RUC_ST_WAIT_CHAIN:
            begin
                if (!chain_enable_in)
                    next_st.state = ruc_pkg::RUC_ST_LOAD;
            end
            ruc_pkg::RUC_ST_LOAD:
            begin
                if (cfg_error)
                begin
                    // A failing factory load retries itself; applications fall back
                    next_st.cause = ruc_pkg::RUC_CAUSE_LOAD_ERR;
                    next_st.page  = ruc_pkg::FACTORY_PAGE;
                    next_st.state = ruc_pkg::RUC_ST_WAIT_CHAIN;
                end
                else if (cfg_done)
                begin
                    next_st.init_cnt = INIT_CNT;
                    next_st.state    = ruc_pkg::RUC_ST_INIT;
                end
            end
            ruc_pkg::RUC_ST_INIT:
            begin
                next_st.wd_cnt = st.wd_load;
                if (st.init_cnt <= 16'h0001)
                    next_st.state = ruc_pkg::RUC_ST_USER;
                else
                    next_st.init_cnt = st.init_cnt - 16'h0001;
            end
            ruc_pkg::RUC_ST_USER:
            begin
                // Count only for an application with watchdog enabled
                if (!factory_active && st.wd_en && !(st.dp_valid && st.dp_write
                    && st.dp_addr == ruc_pkg::ADDR_WD_KICK))
                begin
                    if (st.wd_cnt == 32'h0)
                    begin
                        next_st.cause = ruc_pkg::RUC_CAUSE_WDOG;
                        next_st.page  = ruc_pkg::FACTORY_PAGE;
                        next_st.state = ruc_pkg::RUC_ST_WAIT_CHAIN;
                    end
                    else
                        next_st.wd_cnt = st.wd_cnt - 32'h1;
                end
                // Factory software launches the chosen application
                if (factory_active && st.sw_recfg && st.next_page != ruc_pkg::FACTORY_PAGE)
                begin
                    next_st.page  = st.next_page;
                    next_st.state = ruc_pkg::RUC_ST_WAIT_CHAIN;
                end
            end
            default: next_st.state = ruc_pkg::RUC_ST_POWER;
        endcase

        // Pin-forced reconfiguration overrides everything but power-up
        if (!reconfig_n && st.state != ruc_pkg::RUC_ST_POWER)
        begin
            next_st.cause = ruc_pkg::RUC_CAUSE_PIN;
            next_st.page  = st.local_mode ? st.next_page : ruc_pkg::FACTORY_PAGE;
            next_st.state = ruc_pkg::RUC_ST_WAIT_CHAIN;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st         <= '0;
            st.wd_load <= ruc_pkg::WD_LOAD_RESET;
            st.state   <= ruc_pkg::RUC_ST_POWER;
        end
        else
            st <= next_st;
    end

    // ------------------------------------------------------------
    // PLL serial reprogramming chain
    // ------------------------------------------------------------
    ruc_pll_chain #(
        .WIDTH (PLL_WIDTH)
    ) u_chain (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .start     (st.pll_start),
        .word      (st.pll_word),
        .busy      (pll_busy),
        .sclk_out  (pll_sclk),
        .sdata_out (pll_sdata),
        .update    (pll_update)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata           = st.rdata;
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign page_sel         = st.page;
    assign load_req         = (st.state == ruc_pkg::RUC_ST_LOAD);
    assign cfg_byte_strobe  = st.byte_stb;
    assign cfg_byte         = st.byte_q;
    assign user_io_oe_n     = (st.state != ruc_pkg::RUC_ST_USER);
    assign user_reset       = (st.state == ruc_pkg::RUC_ST_INIT);
    assign user_mode        = (st.state == ruc_pkg::RUC_ST_USER);
    assign chain_enable_out = !(st.state == ruc_pkg::RUC_ST_INIT
                                || st.state == ruc_pkg::RUC_ST_USER);
endmodule

/* File: ruc_pkg.sv */
// Package of constants and types for the remote update configuration loader
package ruc_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_WD_LOAD  = 8'h08;
    localparam logic [7:0] ADDR_WD_KICK  = 8'h0c;
    localparam logic [7:0] ADDR_PLL_CTRL = 8'h10;
    localparam logic [7:0] ADDR_PLL_STAT = 8'h14;
    localparam logic [7:0] ADDR_CMD      = 8'h18;

    // Control and command register fields
    localparam int CTRL_PAGE_LSB  = 0;
    localparam int CTRL_WD_EN_BIT = 4;
    localparam int CTRL_LOCAL_BIT = 5;
    localparam int CMD_RECFG_BIT  = 0;

    // Status register fields
    localparam int STAT_CAUSE_LSB = 0;
    localparam int STAT_PAGE_LSB  = 4;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_USER_BIT  = 12;
    localparam int STAT_FACT_BIT  = 13;

    // Page numbers and reset values
    localparam logic [2:0]  FACTORY_PAGE   = 3'h0;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] WD_LOAD_RESET  = 32'h0000_ffff;

    // Timing: clock rate and init duration
    localparam int CLK_MHZ        = 40;
    localparam int INIT_TIME_NS   = 1000;
    localparam int INIT_CYCLES    = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;

    // Fallback causes
    typedef enum logic [1:0]
    {
        RUC_CAUSE_NONE,
        RUC_CAUSE_WDOG,
        RUC_CAUSE_LOAD_ERR,
        RUC_CAUSE_PIN
    } ruc_cause_e;

    // Sequencer states
    typedef enum logic [2:0]
    {
        RUC_ST_POWER,
        RUC_ST_WAIT_CHAIN,
        RUC_ST_LOAD,
        RUC_ST_INIT,
        RUC_ST_USER,
        RUC_ST_DONE_CHAIN
    } ruc_state_e;

endpackage

/* File: ruc_pll_chain.sv */
// Serial shift chain holding PLL multiply, divide and delay counter settings
`timescale 1ns/1ps
module ruc_pll_chain #(
    parameter int WIDTH = 24
) (
    input  wire logic             hclk,       // System clock
    input  wire logic             hresetn,    // Async reset, active low
    input  wire logic             start,      // Pulse: shift new word
    input  wire logic [WIDTH-1:0] word,       // Word to shift out
    output logic                  busy,       // Shift in progress
    output logic                  sclk_out,   // Serial chain strobe
    output logic                  sdata_out,  // Serial chain data
    output logic                  update      // Pulse: apply chain settings
);
    typedef struct packed
    {
        logic [WIDTH-1:0] shreg;
        logic [7:0]       count;
        logic             busy;
        logic             phase;
        logic             update;
    } ruc_chain_s;

    ruc_chain_s st;
    ruc_chain_s next_st;

    // ------------------------------------------------------------
    // Shifter: two clocks per bit, MSB first; device keeps running
    // ------------------------------------------------------------
    always_comb
    begin
        next_st        = st;
        next_st.update = 1'b0;
        if (!st.busy)
        begin
            if (start)
            begin
                next_st.shreg = word;
                next_st.count = 8'(WIDTH);
                next_st.busy  = 1'b1;
                next_st.phase = 1'b0;
            end
        end
        else if (!st.phase)
        begin
            next_st.phase = 1'b1;
        end
        else
        begin
            next_st.phase = 1'b0;
            next_st.shreg = {st.shreg[WIDTH-2:0], 1'b0};
            next_st.count = st.count - 8'h01;
            if (st.count == 8'h01)
            begin
                next_st.busy   = 1'b0;
                next_st.update = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign busy      = st.busy;
    assign sclk_out  = st.phase;
    assign sdata_out = st.shreg[WIDTH-1];
    assign update    = st.update;
endmodule

/* File: ruc_loader_props.sv */
// Checker of the loader's port behaviour, bound to the loader
`timescale 1ns/1ps
module ruc_loader_props #(
    parameter int PLL_WIDTH = 24
) (
    input wire logic       hclk,             // Clock
    input wire logic       hresetn,          // Reset, active low
    input wire logic       reconfig_n,       // Reload pin
    input wire logic       chain_enable_in,  // Chain enable in
    input wire logic       chain_enable_out, // Chain enable out
    input wire logic [2:0] page_sel,         // Page being loaded
    input wire logic       load_req,         // Load in progress
    input wire logic       cfg_valid,        // Byte valid
    input wire logic [7:0] cfg_data,         // Byte
    input wire logic       cfg_done,         // Image good
    input wire logic       cfg_error,        // Image corrupt
    input wire logic       cfg_byte_strobe,  // Byte accepted
    input wire logic [7:0] cfg_byte,         // Captured byte
    input wire logic       user_io_oe_n,     // User I/O enable, low
    input wire logic       user_reset,       // Init clear
    input wire logic       user_mode,        // User mode
    input wire logic       pll_update        // PLL apply pulse
);
    // ------------------------------------------------------------
    // Helpers and assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] init_cnt;
    logic       seen_load;
    // Init length counter and first-load flag; the power-up load must come from factory
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            init_cnt  <= 8'h00;
            seen_load <= 1'b0;
        end
        else
        begin
            init_cnt  <= user_reset ? init_cnt + 8'h01 : 8'h00;
            seen_load <= seen_load | load_req;
        end
    end
    AST_FIRST_FACTORY: assert property (load_req && !seen_load |-> page_sel == ruc_pkg::FACTORY_PAGE)
        else $error("first load not from factory page");
    AST_TRI_IDLE: assert property (!user_mode |-> user_io_oe_n)
        else $error("user io enabled outside user mode");
    AST_USER_IO: assert property (user_mode |-> !user_io_oe_n && !chain_enable_out)
        else $error("user mode without io or chain enable");
    AST_INIT_LEN: assert property ($fell(user_reset) |-> init_cnt == ruc_pkg::INIT_CYCLES[7:0])
        else $error("init length wrong");
    AST_DONE_INIT: assert property (load_req && cfg_done |=> user_reset && !load_req)
        else $error("good load did not start init");
    AST_ERR_FALLBACK: assert property (load_req && cfg_error |=> page_sel == ruc_pkg::FACTORY_PAGE && !user_mode)
        else $error("load error did not fall back");
    AST_PIN_LEAVE: assert property (user_mode && !reconfig_n |-> ##[1:2] !user_mode)
        else $error("reload pin ignored");
    AST_CHAIN_GATE: assert property ($rose(load_req) |-> $past(chain_enable_in) == 1'b0)
        else $error("load began without chain enable");
    AST_BYTE_TAKE: assert property (load_req && cfg_valid |=> cfg_byte_strobe && cfg_byte == $past(cfg_data))
        else $error("config byte not taken");
    COV_USER: cover property ($rose(user_mode));
    COV_ERR: cover property (load_req && cfg_error);
    COV_PLL: cover property (pll_update);
endmodule
bind ruc_loader ruc_loader_props #(.PLL_WIDTH(PLL_WIDTH)) u_props (.*);

/* File: ruc_cfg_src.sv */
// Behavioural configuration source answering the loader's page requests
`timescale 1ns/1ps
module ruc_cfg_src #(
    parameter int NBYTES   = 16,
    parameter int BAD_PAGE = 5
) (
    input  wire logic       hclk,      // Clock
    input  wire logic       hresetn,   // Reset, active low
    input  wire logic       load_req,  // Load in progress
    input  wire logic [2:0] page_sel,  // Requested page
    input  wire logic       slow,      // Gap after each byte
    output logic            cfg_valid, // Byte valid
    output logic      [7:0] cfg_data,  // Byte
    output logic            cfg_done,  // Image good
    output logic            cfg_error  // Image corrupt
);
    logic [7:0] cnt;
    // Streams the page, then reports; idle data toggles so stale bytes never pass
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt       <= 8'h00;
            cfg_valid <= 1'b0;
            cfg_data  <= 8'h00;
            cfg_done  <= 1'b0;
            cfg_error <= 1'b0;
        end
        else
        begin
            cfg_valid <= 1'b0;
            cfg_done  <= 1'b0;
            cfg_error <= 1'b0;
            cfg_data  <= ~cfg_data;
            if (!load_req)
                cnt <= 8'h00;
            else if (cnt == NBYTES[7:0])
            begin
                cfg_error <= (page_sel == BAD_PAGE[2:0]);
                cfg_done  <= (page_sel != BAD_PAGE[2:0]);
                cnt       <= cnt + 8'h01;
            end
            else if (cnt < NBYTES[7:0] && !(slow && cfg_valid))
            begin
                cfg_valid <= 1'b1;
                cfg_data  <= {page_sel, cnt[4:0]};
                cnt       <= cnt + 8'h01;
            end
        end
    end
endmodule

/* File: ruc_loader_tb.sv */
// Self-checking bench of the remote update loader
`timescale 1ns/1ps
module ruc_loader_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        reconfig_n = 1'b1, chain_enable_in = 1'b0, slow = 1'b0;
    logic [1:0]  htrans = 2'h0, watch = 2'h0;
    logic [2:0]  hsize = 3'h2, page_sel;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, got, exp_v, pll_word, pll_shift = 32'h0;
    logic [31:0] seed = 32'h9682a0ca, cyc = 32'h0;
    logic [31:0] expq[$];
    logic [7:0]  n_upd = 8'h00, cfg_data, cfg_byte;
    logic        hreadyout, hresp, chain_enable_out, load_req, cfg_valid, cfg_done, cfg_error;
    logic        cfg_byte_strobe, user_io_oe_n, user_reset, user_mode, pll_sclk, pll_sdata, pll_update;
    int          n_fail = 0, checks_done = 0;
    ruc_loader u_ruc_loader (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .reconfig_n(reconfig_n), .chain_enable_in(chain_enable_in),
        .chain_enable_out(chain_enable_out), .page_sel(page_sel), .load_req(load_req), .cfg_valid(cfg_valid),
        .cfg_data(cfg_data), .cfg_done(cfg_done), .cfg_error(cfg_error), .cfg_byte_strobe(cfg_byte_strobe),
        .cfg_byte(cfg_byte), .user_io_oe_n(user_io_oe_n), .user_reset(user_reset), .user_mode(user_mode),
        .pll_sclk(pll_sclk), .pll_sdata(pll_sdata), .pll_update(pll_update));
    ruc_cfg_src u_ruc_cfg_src (.hclk(hclk), .hresetn(hresetn), .load_req(load_req), .page_sel(page_sel),
        .slow(slow), .cfg_valid(cfg_valid), .cfg_data(cfg_data), .cfg_done(cfg_done), .cfg_error(cfg_error));
    // ------------------------------------------------------------
    // Clock, watchers and helpers
    // ------------------------------------------------------------
    always #12.5 hclk = ~hclk;
    // PLL chain capture on its strobe, update pulses counted
    always @(posedge pll_sclk) pll_shift <= {pll_shift[30:0], pll_sdata};
    always @(posedge hclk) if (pll_update === 1'b1) n_upd <= n_upd + 8'h01;
    // Compares each noted expectation when its result appears
    always @(posedge hclk)
    begin
        if (watch != 2'h0)
        begin
            got = (watch == 2'h1) ? hrdata : (watch == 2'h2) ?
                {27'h0, hresp, user_mode, user_io_oe_n, chain_enable_out, load_req} : {n_upd, pll_shift[23:0]};
            exp_v = expq.pop_front();
            checks_done++;
            if (got !== exp_v)
            begin
                n_fail++;
                $display("[ERR] %0t kind %0h got %h exp %h", $time, watch, got, exp_v);
            end
        end
    end
    // Hang guard at 20000 cycles, well above the thousand or so cycles the run needs
    always @(posedge hclk)
    begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'h4e20)
        begin
            n_fail++;
            summarize();
        end
    end
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic summarize();
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Single whole-word transfer; a read notes its expected data first
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e = 32'h0);
        if (!w)
            expq.push_back(e);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        watch <= w ? 2'h0 : 2'h1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        watch <= 2'h0;
    endtask
    task automatic probe(input logic [1:0] k, input logic [31:0] e);
        expq.push_back(e);
        @(posedge hclk);
        watch <= k;
        @(posedge hclk);
        watch <= 2'h0;
    endtask
    // Bounded wait for a user mode level; the following check catches a miss
    task automatic wait_user(input logic lvl);
        for (int i = 0; i < 600 && user_mode !== lvl; i++) @(posedge hclk);
    endtask
    task automatic launch(input logic [31:0] ctrl);
        ahb(ruc_pkg::ADDR_CTRL, 1'b1, ctrl);
        ahb(ruc_pkg::ADDR_CMD, 1'b1, 32'h1);
        wait_user(1'b0);
        wait_user(1'b1);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wait_user(1'b1);
        ahb(ruc_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h3400);
        probe(2'h2, 32'h8);
        ahb(ruc_pkg::ADDR_CTRL, 1'b0, 32'h0, ruc_pkg::CTRL_RESET);
        ahb(ruc_pkg::ADDR_WD_LOAD, 1'b0, 32'h0, ruc_pkg::WD_LOAD_RESET);
        ahb(8'h40, 1'b1, xs());
        ahb(8'h40, 1'b0, 32'h0, 32'h0);
        // Short timeout armed while factory runs: must not expire
        ahb(ruc_pkg::ADDR_WD_LOAD, 1'b1, 32'h3);
        ahb(ruc_pkg::ADDR_CTRL, 1'b1, 32'h13);
        repeat (60) @(posedge hclk);
        ahb(ruc_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h3400);
        slow <= 1'b1;
        launch(32'h3);
        ahb(ruc_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h1430);
        pll_word = xs();
        ahb(ruc_pkg::ADDR_PLL_CTRL, 1'b1, pll_word);
        repeat (60) @(posedge hclk);
        probe(2'h3, {8'h01, pll_word[23:0]});
        probe(2'h2, 32'h8);
        // Pin reload held off by the chain enable
        chain_enable_in <= 1'b1;
        reconfig_n <= 1'b0;
        @(posedge hclk);
        reconfig_n <= 1'b1;
        repeat (20) @(posedge hclk);
        probe(2'h2, 32'h6);
        chain_enable_in <= 1'b0;
        wait_user(1'b1);
        ahb(ruc_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h3403);
        launch(32'h5);
        ahb(ruc_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h3402);
        // Page 7 with a watchdog kicked at random spacing, then left to expire
        ahb(ruc_pkg::ADDR_WD_LOAD, 1'b1, 32'h32);
        launch(32'h17);
        for (int k = 0; k < 6; k++)
        begin
            repeat (10 + xs() % 30) @(posedge hclk);
            ahb(ruc_pkg::ADDR_WD_KICK, 1'b1, xs());
        end
        ahb(ruc_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h1472);
        wait_user(1'b0);
        wait_user(1'b1);
        ahb(ruc_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h3401);
        // Local mode through the pin: page 6 loads with no factory pass
        ahb(ruc_pkg::ADDR_CTRL, 1'b1, 32'h26);
        reconfig_n <= 1'b0;
        @(posedge hclk);
        reconfig_n <= 1'b1;
        wait_user(1'b0);
        wait_user(1'b1);
        ahb(ruc_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h1463);
        summarize();
    end
endmodule
